// ===== hw/utr_consts.vh
// Constants of the serial transmitter and receiver core: register offsets,
// field positions, reset values and bit timing counts.
// Assumes inclusion by bare name from the core and test files.
`ifndef UTR_CONSTS_VH
`define UTR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UTR_STATUS_OFF     8'h00
`define UTR_CTRL1_OFF      8'h04
`define UTR_CTRL2_OFF      8'h08
`define UTR_BAUD_OFF       8'h0c
`define UTR_DATA_OFF       8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UTR_S_PARITY_ERROR_FLAG         0
`define UTR_S_NOISE        1
`define UTR_S_FRAME_ERROR_FLAG         2
`define UTR_S_OVR          3
`define UTR_S_AVAIL        4
`define UTR_S_QUIET        5
`define UTR_S_TDONE        6
`define UTR_S_TEMPTY       7
`define UTR_C1_TX9         0
`define UTR_C1_RX9         1
`define UTR_C1_STOP2       2
`define UTR_C1_ODD         3
`define UTR_C1_PAREN       4
`define UTR_C1_NINE        5
`define UTR_C2_RECEIVE_ENABLE        0
`define UTR_C2_TRANSMIT_ENABLE        1
`define UTR_C2_BRK         2
`define UTR_C2_RIE         3
`define UTR_C2_TX_EMPTY_IRQ_ENABLE        4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UTR_CTRL1_RST      6'h00
`define UTR_CTRL2_RST      5'h00
`define UTR_BAUD_RST       8'h00

// ----------------------------------------------------------------------------
// Bit timing in oversample ticks and bit counts
// ----------------------------------------------------------------------------
`define UTR_SUB_LAST       4'hf
`define UTR_SAMPLE_FIRST   4'h7
`define UTR_SAMPLE_LAST    4'h9
`define UTR_BREAK_LAST     4'hc
`define UTR_DATA_LAST8     4'h7
`define UTR_DATA_LAST9     4'h8

`endif

// ===== hw/utr_tick.v
// Oversample tick divider: one pulse every divisor plus one clocks.
// Assumes divisor is held steady while run is high.
`timescale 1ns/100ps

module utr_tick #(
	parameter WIDTH = 8
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             run,
	input  wire [WIDTH-1:0] divisor,
	output reg              tick
);

	reg [WIDTH-1:0] count;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= {WIDTH{1'b0}};
			tick  <= 1'b0;
		end
		else if (!run)
		begin
			count <= {WIDTH{1'b0}};
			tick  <= 1'b0;
		end
		else if (count == {WIDTH{1'b0}})
		begin
			count <= divisor;
			tick  <= 1'b1;
		end
		else
		begin
			count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
			tick  <= 1'b0;
		end
	end

endmodule // utr_tick

// ===== hw/utr_core.v
// Serial transmitter and receiver core with an APB register slave.
// Assumes pclk at 25 MHz and rxd already synchronous to pclk.
`timescale 1ns/100ps
`include "utr_consts.vh"

// Operation
// - Transmit frames least significant bit first.
// - Ninth transmit bit comes from control bit.
// - Data writes blocked while transmit-empty clear.
// - Status access then data write clears flags.
// - Transmit-empty set by hardware, requests interrupt.
// - Write during frame waits in buffer.
// - Idle write loads shifter, keeps empty set.
// - Transmit-done set at end of frame.
// - Break is start plus 13N zeros.
// - Break repeats until cleared, then stop_count_select.
// - Receive LSB first, ninth bit kept.
// - Receive recovery runs sixteen times bit rate.
// - Each bit is three-sample majority.
// - After stop sample, word enters buffer.
// - Two words buffered, third overruns.
// - Receive enable starts the start-bit hunt.
// - Avail flag, interrupt on word or overrun.
// - Status access then reading last word clears avail.
// - Break gives frame error, zeros, idle.
// - After bad stop, wait for high.
// - Quiet flag low from start to stop.
// - Transmit one or two stop_count_select, check one.
// - Parity even, odd or off, shared format.
// - Idle transmit line is driven high.
module utr_core #(
	parameter BAUD_W = 8
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        rxd,
	output reg         txd,
	output reg         tx_irq,
	output reg         rx_irq
);

	localparam T_IDLE  = 3'h0;
	localparam T_START = 3'h1;
	localparam T_DATA  = 3'h2;
	localparam T_PAR   = 3'h3;
	localparam T_BRK   = 3'h4;
	localparam T_STOP  = 3'h5;
	localparam R_HUNT  = 3'h0;
	localparam R_START = 3'h1;
	localparam R_DATA  = 3'h2;
	localparam R_PAR   = 3'h3;
	localparam R_STOP  = 3'h4;
	localparam R_WAIT  = 3'h5;

	// ------------------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------------------
	reg [5:0]        control_reg_one;
	reg [4:0]        control_reg_two;
	reg [BAUD_W-1:0] baud_divisor;
	reg              status_seen;
	reg [2:0]        tx_state;
	reg [3:0]        tx_sub;
	reg [3:0]        tx_cnt;
	reg [8:0]        tx_shift_reg;
	reg [8:0]        tx_buf;
	reg              tx_full;
	reg              tx_par;
	reg              tx_brk;
	reg              tx_empty_flag;
	reg              tx_done_flag;
	reg [2:0]        rx_state;
	reg [3:0]        rx_sub;
	reg [3:0]        rx_cnt;
	reg [8:0]        rx_shift_reg;
	reg [2:0]        rx_samp;
	reg              rx_par;
	reg              rx_noisy;
	reg [8:0]        rx_mem0;
	reg [8:0]        rx_mem1;
	reg [1:0]        rx_count;
	reg              rx_avail_flag;
	reg              overrun_flag;
	reg              frame_error_flag;
	reg              parity_error_flag;
	reg              noise_flag;
	reg              rx_quiet_flag;
	reg              next_rx_push;
	reg              next_rx_frame_error_flag;
	reg              next_rx_parity_error_flag;

	wire tx_ninth_bit      = control_reg_one[`UTR_C1_TX9];
	wire stop_count_select = control_reg_one[`UTR_C1_STOP2];
	wire parity_odd_select = control_reg_one[`UTR_C1_ODD];
	wire parity_enable     = control_reg_one[`UTR_C1_PAREN];
	wire nine_bit_select   = control_reg_one[`UTR_C1_NINE];
	wire receive_enable    = control_reg_two[`UTR_C2_RECEIVE_ENABLE];
	wire transmit_enable   = control_reg_two[`UTR_C2_TRANSMIT_ENABLE];
	wire send_break        = control_reg_two[`UTR_C2_BRK];
	wire rx_irq_enable     = control_reg_two[`UTR_C2_RIE];
	wire tx_irq_enable     = control_reg_two[`UTR_C2_TX_EMPTY_IRQ_ENABLE];
	wire rx_ninth_bit      = rx_mem0[8];
	wire tick;

	// ------------------------------------------------------------------------
	// APB access decode
	// ------------------------------------------------------------------------
	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready;
	wire hit_stat = (paddr == `UTR_STATUS_OFF);
	wire hit_data = (paddr == `UTR_DATA_OFF);
	wire data_wr  = access & pwrite & hit_data & tx_empty_flag;
	wire data_rd  = access & ~pwrite & hit_data;
	wire [3:0] data_last = nine_bit_select ? `UTR_DATA_LAST9 : `UTR_DATA_LAST8;
	wire [8:0] wr_word = {nine_bit_select & tx_ninth_bit, pwdata[7:0]};
	wire wr_par = ^wr_word ^ parity_odd_select;
	wire buf_par = ^tx_buf ^ parity_odd_select;
	wire [7:0] status_word = {tx_empty_flag, tx_done_flag, rx_quiet_flag, rx_avail_flag,
		overrun_flag, frame_error_flag, noise_flag, parity_error_flag};
	reg [31:0] next_rdata;
	reg        next_err;

	always @*
	begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		if (hit_stat)
			next_rdata[7:0] = status_word;
		else if (paddr == `UTR_CTRL1_OFF)
			next_rdata[5:0] = {control_reg_one[5:2], rx_ninth_bit, control_reg_one[0]};
		else if (paddr == `UTR_CTRL2_OFF)
			next_rdata[4:0] = control_reg_two;
		else if (paddr == `UTR_BAUD_OFF)
			next_rdata[BAUD_W-1:0] = baud_divisor;
		else if (hit_data)
		begin
			next_rdata[7:0] = rx_mem0[7:0];
			next_err        = pwrite & ~tx_empty_flag;
		end
		else
			next_err = 1'b1;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata          <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
			control_reg_one <= `UTR_CTRL1_RST;
			control_reg_two <= `UTR_CTRL2_RST;
			baud_divisor    <= `UTR_BAUD_RST;
			status_seen     <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			prdata  <= setup ? next_rdata : 32'h0000_0000;
			pslverr <= setup & next_err;
			if (access & pwrite)
			begin
				if (paddr == `UTR_CTRL1_OFF)
					control_reg_one <= {pwdata[5:2], 1'b0, pwdata[0]};
				else if (paddr == `UTR_CTRL2_OFF)
					control_reg_two <= pwdata[4:0];
				else if (paddr == `UTR_BAUD_OFF)
					baud_divisor <= pwdata[BAUD_W-1:0];
			end
			if (access & hit_stat)
				status_seen <= 1'b1;
			else if (access & hit_data)
				status_seen <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Oversample clock, sixteen ticks per bit
	// ------------------------------------------------------------------------
	utr_tick #(
		.WIDTH   (BAUD_W)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (transmit_enable | receive_enable),
		.divisor (baud_divisor),
		.tick    (tick)
	);

	// ------------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------------
	wire tx_bit_end   = tick & (tx_sub == `UTR_SUB_LAST);
	wire tx_frame_end = (tx_state == T_STOP) & tx_bit_end & (tx_cnt[0] == stop_count_select);
	wire tx_free      = (tx_state == T_IDLE) | tx_frame_end;
	wire tx_direct    = data_wr & tx_free & ~tx_full & ~send_break;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state      <= T_IDLE;
			tx_sub        <= 4'h0;
			tx_cnt        <= 4'h0;
			tx_shift_reg  <= 9'h000;
			tx_buf        <= 9'h000;
			tx_full       <= 1'b0;
			tx_par        <= 1'b0;
			tx_brk        <= 1'b0;
			tx_empty_flag <= 1'b1;
			tx_done_flag  <= 1'b1;
			txd           <= 1'b1;
			tx_irq        <= 1'b0;
		end
		else if (!transmit_enable)
		begin
			tx_state      <= T_IDLE;
			tx_sub        <= 4'h0;
			tx_full       <= 1'b0;
			tx_brk        <= 1'b0;
			tx_empty_flag <= 1'b1;
			tx_done_flag  <= 1'b1;
			txd           <= 1'b1;
			tx_irq        <= 1'b0;
		end
		else
		begin
			tx_irq <= tx_irq_enable & tx_empty_flag & ~tx_brk & ~send_break;
			if (tick)
				tx_sub <= tx_sub + 4'h1;
			if (data_wr & status_seen)
			begin
				tx_empty_flag <= 1'b0;
				tx_done_flag  <= 1'b0;
			end
			if (data_wr & ~tx_direct)
			begin
				tx_buf        <= wr_word;
				tx_full       <= 1'b1;
				tx_empty_flag <= 1'b0;
			end
			if (tx_frame_end)
				tx_done_flag <= 1'b1;
			if (tx_free)
			begin
				tx_sub <= 4'h0;
				tx_cnt <= 4'h0;
				if (send_break)
				begin
					tx_state <= T_START;
					tx_brk   <= 1'b1;
					txd      <= 1'b0;
				end
				else if (tx_full)
				begin
					tx_state      <= T_START;
					tx_shift_reg  <= tx_buf;
					tx_par        <= buf_par;
					tx_full       <= 1'b0;
					tx_brk        <= 1'b0;
					tx_empty_flag <= 1'b1;
					txd           <= 1'b0;
				end
				else if (tx_direct)
				begin
					tx_state      <= T_START;
					tx_shift_reg  <= wr_word;
					tx_par        <= wr_par;
					tx_brk        <= 1'b0;
					tx_empty_flag <= 1'b1;
					txd           <= 1'b0;
				end
				else
				begin
					tx_state <= T_IDLE;
					tx_brk   <= 1'b0;
					txd      <= 1'b1;
				end
			end
			else if (tx_bit_end)
			begin
				case (tx_state)
					T_START:
					begin
						tx_cnt <= 4'h0;
						if (tx_brk)
						begin
							tx_state <= T_BRK;
							txd      <= 1'b0;
						end
						else
						begin
							tx_state     <= T_DATA;
							txd          <= tx_shift_reg[0];
							tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
						end
					end
					T_DATA:
					begin
						if (tx_cnt == data_last)
						begin
							tx_cnt <= 4'h0;
							if (parity_enable)
							begin
								tx_state <= T_PAR;
								txd      <= tx_par;
							end
							else
							begin
								tx_state <= T_STOP;
								txd      <= 1'b1;
							end
						end
						else
						begin
							tx_cnt       <= tx_cnt + 4'h1;
							txd          <= tx_shift_reg[0];
							tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
						end
					end
					T_PAR:
					begin
						tx_state <= T_STOP;
						txd      <= 1'b1;
					end
					T_BRK:
					begin
						if (tx_cnt != `UTR_BREAK_LAST)
							tx_cnt <= tx_cnt + 4'h1;
						else if (send_break)
							tx_cnt <= 4'h0;
						else
						begin
							tx_state <= T_STOP;
							tx_cnt   <= 4'h0;
							txd      <= 1'b1;
						end
					end
					T_STOP:
						tx_cnt <= tx_cnt + 4'h1;
					default:
						tx_state <= T_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------------
	wire rx_bit_end = tick & (rx_sub == `UTR_SUB_LAST);
	wire rx_maj = (rx_samp[0] & rx_samp[1]) | (rx_samp[0] & rx_samp[2]) |
		(rx_samp[1] & rx_samp[2]);
	wire rx_noise_bit = (rx_samp != 3'h0) & (rx_samp != 3'h7);
	wire [8:0] rx_word = nine_bit_select ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
	wire rx_pop = data_rd & (rx_count != 2'h0);

	always @*
	begin
		next_rx_push = (rx_state == R_STOP) & rx_bit_end;
		next_rx_frame_error_flag = ~rx_maj;
		next_rx_parity_error_flag = parity_enable & (rx_par != parity_odd_select);
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_state          <= R_HUNT;
			rx_sub            <= 4'h0;
			rx_cnt            <= 4'h0;
			rx_shift_reg      <= 9'h000;
			rx_samp           <= 3'h7;
			rx_par            <= 1'b0;
			rx_noisy          <= 1'b0;
			rx_mem0           <= 9'h000;
			rx_mem1           <= 9'h000;
			rx_count          <= 2'h0;
			rx_avail_flag     <= 1'b0;
			overrun_flag      <= 1'b0;
			frame_error_flag  <= 1'b0;
			parity_error_flag <= 1'b0;
			noise_flag        <= 1'b0;
			rx_quiet_flag     <= 1'b1;
			rx_irq            <= 1'b0;
		end
		else
		begin
			rx_irq <= rx_irq_enable & next_rx_push;
			if (tick)
				rx_sub <= rx_sub + 4'h1;
			if (tick & (rx_sub >= `UTR_SAMPLE_FIRST) & (rx_sub <= `UTR_SAMPLE_LAST))
				rx_samp <= {rx_samp[1:0], rxd};
			if (rx_pop)
			begin
				rx_mem0 <= rx_mem1;
				if (status_seen)
				begin
					overrun_flag <= 1'b0;
					noise_flag   <= 1'b0;
					if (rx_count == 2'h1)
						rx_avail_flag <= 1'b0;
				end
			end
			if (next_rx_push)
			begin
				frame_error_flag  <= next_rx_frame_error_flag;
				parity_error_flag <= next_rx_parity_error_flag;
				noise_flag        <= rx_noisy | rx_noise_bit;
				rx_avail_flag     <= 1'b1;
				if (rx_count == 2'h2 && !rx_pop)
					overrun_flag <= 1'b1;
				else if (rx_count == 2'h0 || (rx_count == 2'h1 && rx_pop))
					rx_mem0 <= rx_word;
				else
					rx_mem1 <= rx_word;
				if (rx_count != 2'h2 && !rx_pop)
					rx_count <= rx_count + 2'h1;
			end
			else if (rx_pop)
				rx_count <= rx_count - 2'h1;
			if (!receive_enable)
			begin
				rx_state      <= R_HUNT;
				rx_quiet_flag <= 1'b1;
			end
			else
			begin
				case (rx_state)
					R_HUNT:
					begin
						if (tick & ~rxd)
						begin
							rx_state      <= R_START;
							rx_sub        <= 4'h0;
							rx_quiet_flag <= 1'b0;
						end
					end
					R_START:
					begin
						if (rx_bit_end)
						begin
							rx_cnt   <= 4'h0;
							rx_par   <= 1'b0;
							rx_noisy <= rx_noise_bit;
							if (rx_maj)
							begin
								rx_state      <= R_HUNT;
								rx_quiet_flag <= 1'b1;
							end
							else
								rx_state <= R_DATA;
						end
					end
					R_DATA:
					begin
						if (rx_bit_end)
						begin
							rx_shift_reg <= {rx_maj, rx_shift_reg[8:1]};
							rx_par       <= rx_par ^ rx_maj;
							rx_noisy     <= rx_noisy | rx_noise_bit;
							rx_cnt       <= rx_cnt + 4'h1;
							if (rx_cnt == data_last)
								rx_state <= parity_enable ? R_PAR : R_STOP;
						end
					end
					R_PAR:
					begin
						if (rx_bit_end)
						begin
							rx_par   <= rx_par ^ rx_maj;
							rx_noisy <= rx_noisy | rx_noise_bit;
							rx_state <= R_STOP;
						end
					end
					R_STOP:
					begin
						if (rx_bit_end)
						begin
							rx_quiet_flag <= 1'b1;
							rx_state      <= rx_maj ? R_HUNT : R_WAIT;
						end
					end
					R_WAIT:
					begin
						if (tick & rxd)
							rx_state <= R_HUNT;
					end
					default:
						rx_state <= R_HUNT;
				endcase
			end
		end
	end

endmodule // utr_core

// ===== test/utr_core_props.sv
// Checker for utr_core: APB handshake, read data, error response and line timing.
// Assumes it is bound to utr_core; bit timing is judged only while the divisor is zero.
`timescale 1ns/100ps
`include "utr_consts.vh"

module utr_props #(
	parameter BAUD_W = 8
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        rxd,
	input wire        txd,
	input wire        tx_irq,
	input wire        rx_irq
);
	reg div_zero;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A bit is 16 clocks only with a zero divisor, so the line timing check follows the baud writes.
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			div_zero <= 1'b1;
		else if (psel && penable && pready && pwrite && paddr == `UTR_BAUD_OFF)
			div_zero <= pwdata[BAUD_W-1:0] == {BAUD_W{1'b0}};

	sequence setup_phase;
		psel && !penable;
	endsequence
	sequence low_bit;
		!txd [*8] ##1 !txd [*8];
	endsequence

	chk_ready_after_setup: assert property (setup_phase |=> pready && penable)
		else $error("no ready in the access phase");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_ready_needs_setup: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
		else $error("ready without a setup cycle");
	chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside the access phase");
	chk_err_with_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("error response without ready");
	chk_unmapped_error: assert property (
		(setup_phase and (paddr > `UTR_DATA_OFF)) |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	// The previous cycle must not be an access, since a write there can fill the buffer after tx_irq was launched.
	chk_empty_write_ok: assert property (
		(setup_phase and (pwrite && paddr == `UTR_DATA_OFF && tx_irq && !$past(pready))) |=> !pslverr)
		else $error("data write refused while empty");
	chk_rx_irq_pulse: assert property (rx_irq |=> !rx_irq)
		else $error("receive interrupt longer than one cycle");
	chk_low_bit_len: assert property (div_zero && $fell(txd) |-> low_bit)
		else $error("low level on the line shorter than one bit");
endmodule // utr_props

bind utr_core utr_props #(.BAUD_W(BAUD_W)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// ===== test/utr_remote.sv
// Remote serial end: sends frames on rxd and collects frames seen on txd.
// Assumes a zero divisor in the core, so one bit lasts 16 clocks.
`timescale 1ns/100ps

module utr_remote (
	input  wire       pclk,
	input  wire       txd,
	input  wire [3:0] frame_bits,
	output reg        rxd
);
	reg [15:0] rx_q [$];
	reg [15:0] word;
	integer    i;

	initial
		rxd = 1'b1;

	// Samples each bit in its middle, LSB first; positions past the frame read as high.
	always
	begin
		@(negedge txd);
		repeat (8) @(posedge pclk);
		word = 16'hffff;
		for (i = 0; i < frame_bits; i = i + 1)
		begin
			repeat (16) @(posedge pclk);
			word[i] = txd;
		end
		rx_q.push_back(word);
	end

	// Start bit, then n bits LSB first; one bit may carry a one-clock glitch in its middle.
	task send(input [15:0] bits, input integer n, input integer glitch);
		integer b;
		integer k;
		begin
			for (b = -1; b < n; b = b + 1)
				for (k = 0; k < 16; k = k + 1)
				begin
					@(posedge pclk);
					rxd <= (b < 0 ? 1'b0 : bits[b]) ^ (b == glitch && k == 8);
				end
			@(posedge pclk);
			rxd <= 1'b1;
		end
	endtask
endmodule // utr_remote

// ===== test/utr_core_bench.sv
// Testbench for utr_core: registers over APB, transmit and receive against the remote model.
// Assumes utr_remote on the line and the checker bound to the core; divisor stays zero.
`timescale 1ns/100ps
`include "utr_consts.vh"

module utr_core_bench;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg  [3:0]  frame_bits = 4'h9;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        rxd;
	wire        txd;
	wire        tx_irq;
	wire        rx_irq;
	integer     fail_count = 0;
	integer     check_count = 0;
	integer     irq_seen = 0;
	integer     low_run = 0;
	integer     last_low = 0;
	integer     i;
	integer     base;
	reg  [31:0] rd_data;
	reg  [5:0]  cfg [0:2];
	reg  [7:0]  dat [0:2];

	utr_core dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq)
	);
	utr_remote remote (.pclk(pclk), .txd(txd), .frame_bits(frame_bits), .rxd(rxd));

	always #20 pclk = ~pclk;

	// Counts receive interrupts and measures long low stretches on the transmit line.
	always @(posedge pclk)
	begin
		if (rx_irq === 1'b1)
			irq_seen <= irq_seen + 1;
		low_run <= (txd === 1'b0) ? low_run + 1 : 0;
		if (txd === 1'b1 && low_run > 100)
			last_low <= low_run;
	end

	task check(input string name, input [31:0] exp, input [31:0] got);
	begin
		check_count = check_count + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	task apb(input w, input [7:0] a, input [31:0] d, input err);
		integer n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1)
			begin
				@(posedge pclk);
				n = n + 1;
			end
			rd_data = prdata;
			check("pready wait", 32'h0, n);
			check("pslverr", {31'h0, err}, {31'h0, pslverr});
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task rcheck(input string name, input [7:0] a, input [31:0] exp, input err);
	begin
		apb(1'b0, a, 32'h0, err);
		check(name, exp, rd_data);
	end
	endtask

	task take(input [15:0] exp);
		integer n;
		begin
			n = 0;
			while (remote.rx_q.size() == 0 && n < 800)
			begin
				@(posedge pclk);
				n = n + 1;
			end
			check("tx frame", {16'h0, exp}, (n < 800) ? {16'h0, remote.rx_q.pop_front()} : 32'hx);
		end
	endtask

	// Frame bits after the start bit: data, ninth bit, parity, then high stop and idle positions.
	function [15:0] frame(input [5:0] c, input [7:0] d);
	begin
		frame = 16'hffff;
		frame[7:0] = d;
		if (c[5])
			frame[8] = c[0];
		if (c[4])
			frame[8 + c[5]] = ^d ^ (c[5] & c[0]) ^ c[3];
	end
	endfunction

	function [3:0] flen(input [5:0] c);
		flen = 4'd9 + c[5] + c[4] + c[2];
	endfunction

	task close_out;
	begin
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	initial
	begin
		repeat (12000) @(posedge pclk);
		fail_count = fail_count + 1;
		close_out;
	end

	initial
	begin
		cfg[0] = 6'h35;
		cfg[1] = 6'h1c;
		cfg[2] = 6'h10;
		dat[0] = 8'h5a;
		dat[1] = 8'h0f;
		dat[2] = 8'hc3;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
		rcheck("ctrl1", `UTR_CTRL1_OFF, 32'h0, 1'b0);
		rcheck("ctrl2", `UTR_CTRL2_OFF, 32'h0, 1'b0);
		rcheck("baud", `UTR_BAUD_OFF, 32'h0, 1'b0);
		rcheck("unmapped", 8'h14, 32'h0, 1'b1);
		apb(1'b1, 8'h14, 32'hff, 1'b1);
		remote.send(frame(6'h0, 8'h99), 10, 99);
		rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
		apb(1'b1, `UTR_CTRL2_OFF, 32'h1b, 1'b0);
		rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
		check("tx irq", 32'h1, {31'h0, tx_irq});
		apb(1'b1, `UTR_DATA_OFF, 32'ha5, 1'b0);
		rcheck("status", `UTR_STATUS_OFF, 32'ha0, 1'b0);
		apb(1'b1, `UTR_DATA_OFF, 32'h3c, 1'b0);
		rcheck("status", `UTR_STATUS_OFF, 32'h20, 1'b0);
		check("tx irq", 32'h0, {31'h0, tx_irq});
		apb(1'b1, `UTR_DATA_OFF, 32'h77, 1'b1);
		take(frame(6'h0, 8'ha5));
		take(frame(6'h0, 8'h3c));
		rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
		for (i = 0; i < 3; i = i + 1)
		begin
			apb(1'b1, `UTR_CTRL1_OFF, {26'h0, cfg[i]}, 1'b0);
			frame_bits <= flen(cfg[i]);
			rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
			apb(1'b1, `UTR_DATA_OFF, {24'h0, dat[i]}, 1'b0);
			take(frame(cfg[i], dat[i]));
			remote.send(frame(cfg[i], dat[i]), flen(cfg[i]), 99);
			repeat (4) @(posedge pclk);
			rcheck("status", `UTR_STATUS_OFF, 32'hf0, 1'b0);
			rcheck("ctrl1", `UTR_CTRL1_OFF, {26'h0, cfg[i] | {cfg[i][5] & cfg[i][0], 1'b0}}, 1'b0);
			rcheck("data", `UTR_DATA_OFF, {24'h0, dat[i]}, 1'b0);
		end
		apb(1'b1, `UTR_CTRL1_OFF, 32'h0, 1'b0);
		frame_bits <= 4'h9;
		fork
			remote.send(frame(6'h0, 8'h0f), 10, 2);
			begin
				repeat (60) @(posedge pclk);
				rcheck("status", `UTR_STATUS_OFF, 32'hc0, 1'b0);
			end
		join
		repeat (4) @(posedge pclk);
		rcheck("status", `UTR_STATUS_OFF, 32'hf2, 1'b0);
		rcheck("data", `UTR_DATA_OFF, 32'h0f, 1'b0);
		base = irq_seen;
		for (i = 1; i < 4; i = i + 1)
			remote.send(frame(6'h0, {i[3:0], i[3:0]}), 10, 99);
		repeat (4) @(posedge pclk);
		check("rx irqs", 32'h3, irq_seen - base);
		rcheck("status", `UTR_STATUS_OFF, 32'hf8, 1'b0);
		rcheck("data", `UTR_DATA_OFF, 32'h11, 1'b0);
		rcheck("status", `UTR_STATUS_OFF, 32'hf0, 1'b0);
		rcheck("data", `UTR_DATA_OFF, 32'h22, 1'b0);
		rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
		base = irq_seen;
		remote.send(16'h0, 15, 99);
		repeat (4) @(posedge pclk);
		check("rx irqs", 32'h1, irq_seen - base);
		rcheck("status", `UTR_STATUS_OFF, 32'hf4, 1'b0);
		rcheck("data", `UTR_DATA_OFF, 32'h0, 1'b0);
		remote.send(frame(6'h0, 8'h42), 10, 99);
		repeat (4) @(posedge pclk);
		rcheck("status", `UTR_STATUS_OFF, 32'hf0, 1'b0);
		rcheck("data", `UTR_DATA_OFF, 32'h42, 1'b0);
		apb(1'b1, `UTR_CTRL2_OFF, 32'h1f, 1'b0);
		rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
		check("tx irq", 32'h0, {31'h0, tx_irq});
		apb(1'b1, `UTR_DATA_OFF, 32'h0, 1'b0);
		apb(1'b1, `UTR_CTRL2_OFF, 32'h1b, 1'b0);
		for (i = 0; last_low == 0 && i < 600; i = i + 1)
			@(posedge pclk);
		check("break len", 32'd224, last_low);
		repeat (40) @(posedge pclk);
		rcheck("status", `UTR_STATUS_OFF, 32'he0, 1'b0);
		close_out;
	end
endmodule // utr_core_bench
